// [verilog/gco_ctrl.sv]
// Output timing and conditioning stage of the composite converter
`timescale 1ns/1ps
`default_nettype none
module gco_ctrl #(
  parameter int unsigned DEPTH = gco_pkg::FIFO_DEPTH
) (
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic                        genlock_en,
  input  wire logic [gco_pkg::CNT_W-1:0]   vert_offset,
  input  wire logic [gco_pkg::CNT_W-1:0]   horz_offset,
  input  wire logic [gco_pkg::FINE_W-1:0]  fine_offset,
  input  wire logic [gco_pkg::DEG_W-1:0]   sch_adjust,
  input  wire logic [gco_pkg::DEG_W-1:0]   ref_sch_phase,
  input  wire logic                        vblank_wide,
  input  wire logic [1:0]                  mute_mode,
  input  wire logic [1:0]                  pattern_sel,
  input  wire logic                        setup_en,
  input  wire logic                        ref_present,
  input  wire logic                        ref_vsync,
  input  wire logic                        in_locked,
  input  wire logic                        in_frame_start,
  input  wire logic                        in_line_625,
  input  wire logic                        in_valid,
  input  wire logic [gco_pkg::PIX_W-1:0]   in_data,
  output logic                             in_ready_q,
  output logic [gco_pkg::PIX_W-1:0]        out_data_q,
  output logic                             out_blank_q,
  output logic                             out_hsync_q,
  output logic                             out_vsync_q,
  output logic                             out_std625_q,
  output logic                             out_genlocked_q,
  output logic [gco_pkg::FINE_W-1:0]       fine_phase_q,
  output logic [gco_pkg::DEG_W-1:0]        sch_phase_q,
  output logic                             freeze_q
);
  // Pin inputs pass two flops; third stage only feeds edge detects
  logic [4:0] pin_meta_q, pin_sync_q;
  logic       ref_vs_prev_q, in_fs_prev_q;
  logic       ref_ok, in_ok, line625_pin, ref_edge, in_edge;

  always_ff @(posedge clock) begin
    if (srst) begin
      pin_meta_q    <= '0;
      pin_sync_q    <= '0;
      ref_vs_prev_q <= 1'b0;
      in_fs_prev_q  <= 1'b0;
    end else begin
      pin_meta_q    <= {ref_present, ref_vsync, in_locked, in_frame_start, in_line_625};
      pin_sync_q    <= pin_meta_q;
      ref_vs_prev_q <= pin_sync_q[3];
      in_fs_prev_q  <= pin_sync_q[1];
    end
  end

  always_comb begin
    ref_ok      = pin_sync_q[4];
    in_ok       = pin_sync_q[2];
    line625_pin = pin_sync_q[0];
    ref_edge    = pin_sync_q[3] && !ref_vs_prev_q;
    in_edge     = pin_sync_q[1] && !in_fs_prev_q;
  end

  // Timing state
  logic [gco_pkg::CNT_W-1:0] h_q, h_d, v_q, v_d, h_total, v_total, vb_last;
  logic                      std625_q, std625_d;
  logic [1:0]                mute_q, mute_d, pat_q, pat_d;
  logic                      locked_mode, frame_end;

  // Reference lock only with genlock on and a reference seen
  always_comb begin
    locked_mode = genlock_en && ref_ok;
    h_total     = std625_q ? gco_pkg::H_TOTAL_625 : gco_pkg::H_TOTAL_525;
    v_total     = std625_q ? gco_pkg::V_TOTAL_625 : gco_pkg::V_TOTAL_525;
    frame_end   = (h_q == h_total - 1'b1) && (v_q == v_total - 1'b1);
    h_d         = (h_q == h_total - 1'b1) ? '0 : h_q + 1'b1;
    v_d         = (h_q == h_total - 1'b1) ? ((v_q == v_total - 1'b1) ? '0 : v_q + 1'b1) : v_q;
    std625_d    = std625_q;
    mute_d      = mute_q;
    pat_d       = pat_q;
    if (frame_end) begin
      std625_d = line625_pin;
      mute_d   = mute_mode;
      pat_d    = pattern_sel;
    end
    if (locked_mode && ref_edge) begin
      // Reference frame start lands on the programmed offsets
      h_d = (horz_offset < h_total) ? horz_offset : '0;
      v_d = (vert_offset < v_total) ? vert_offset : '0;
    end else if (!genlock_en && in_edge) begin
      // Reference ignored; output follows input frame start
      h_d = '0;
      v_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      h_q      <= '0;
      v_q      <= '0;
      std625_q <= 1'b0;
      mute_q   <= gco_pkg::GCO_MUTE_NONE;
      pat_q    <= gco_pkg::GCO_PAT_OFF;
    end else begin
      h_q      <= h_d;
      v_q      <= v_d;
      std625_q <= std625_d;
      mute_q   <= mute_d;
      pat_q    <= pat_d;
    end
  end

  // Input samples through the FIFO; drained only in active picture
  logic                      f_valid, pop, blank, noisy;
  logic [gco_pkg::PIX_W-1:0] f_data;

  always_comb begin
    if (std625_q) begin
      vb_last = vblank_wide ? gco_pkg::VB_WIDE_625 : gco_pkg::VB_NARROW_625;
    end else begin
      vb_last = vblank_wide ? gco_pkg::VB_WIDE_525 : gco_pkg::VB_NARROW_525;
    end
    blank = (v_q < vb_last) || (h_q < gco_pkg::H_ACTIVE_START);
    pop   = !blank;
    noisy = !in_ok;
  end

  gco_fifo #(
    .WIDTH (gco_pkg::PIX_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .s_valid   (in_valid),
    .s_data    (in_data),
    .s_ready_q (in_ready_q),
    .m_valid   (f_valid),
    .m_data    (f_data),
    .m_ready   (pop)
  );

  // Output conditioning; pattern wins over mute, mute over video
  logic [gco_pkg::PIX_W-1:0] pix_d;
  logic [gco_pkg::PIX_W:0]   lifted;
  logic [gco_pkg::CNT_W:0]   sch_sum;
  logic [gco_pkg::DEG_W-1:0] sch_d;
  logic                      freeze_d;
  localparam int unsigned    CNT_W_EXT = gco_pkg::CNT_W + 1;  // Sum width, room for one carry

  always_comb begin
    lifted   = {1'b0, f_data} + {1'b0, gco_pkg::SETUP_OFFSET};
    freeze_d = (mute_q == gco_pkg::GCO_FREEZE_NOISE) && noisy;
    pix_d    = f_valid ? f_data : gco_pkg::BLACK_LEVEL;
    if (!std625_q && setup_en && f_valid) begin
      pix_d = (lifted > {1'b0, gco_pkg::PIX_MAX}) ? gco_pkg::PIX_MAX : lifted[gco_pkg::PIX_W-1:0];
    end
    if ((mute_q == gco_pkg::GCO_MUTE_NOISE) && noisy) begin
      pix_d = gco_pkg::BLACK_LEVEL;
    end
    case (pat_q)
      gco_pkg::GCO_PAT_BLACK: pix_d = gco_pkg::BLACK_LEVEL;
      gco_pkg::GCO_PAT_BARS:  pix_d = gco_pkg::bar_level(3'(h_q >> gco_pkg::BAR_SHIFT));
      default:                pix_d = pix_d;
    endcase
    if (blank) begin
      pix_d = gco_pkg::BLACK_LEVEL;
    end
    // ScH held to the reference when locked, trimmed in one-degree steps
    sch_sum = (CNT_W_EXT'(ref_sch_phase)) + (CNT_W_EXT'(sch_adjust));
    if (!locked_mode) begin
      sch_sum = CNT_W_EXT'(sch_adjust);
    end
    if (sch_sum >= {1'b0, gco_pkg::DEG_FULL}) begin
      sch_sum = sch_sum - {1'b0, gco_pkg::DEG_FULL};
    end
    sch_d = sch_sum[gco_pkg::DEG_W-1:0];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      out_data_q      <= gco_pkg::BLACK_LEVEL;
      out_blank_q     <= 1'b1;
      out_hsync_q     <= 1'b0;
      out_vsync_q     <= 1'b0;
      out_std625_q    <= 1'b0;
      out_genlocked_q <= 1'b0;
      fine_phase_q    <= '0;
      sch_phase_q     <= '0;
      freeze_q        <= 1'b0;
    end else begin
      out_data_q      <= pix_d;
      out_blank_q     <= blank;
      out_hsync_q     <= (h_q == '0);
      out_vsync_q     <= (h_q == '0) && (v_q == '0);
      out_std625_q    <= std625_q;
      out_genlocked_q <= locked_mode;
      fine_phase_q    <= locked_mode ? fine_offset : '0;
      sch_phase_q     <= sch_d;
      freeze_q        <= freeze_d;
    end
  end

  // Checks on the output stage
  a_genlock_flag: assert property (@(posedge clock) disable iff (srst)
    ##1 (out_genlocked_q == $past(genlock_en && ref_ok)))
    else $error("genlock status does not follow enable and reference");
  a_vert_offset: assert property (@(posedge clock) disable iff (srst)
    (locked_mode && ref_edge && vert_offset < v_total) |=> (v_q == $past(vert_offset)))
    else $error("vertical offset not applied at reference frame start");
  a_horz_offset: assert property (@(posedge clock) disable iff (srst)
    (locked_mode && ref_edge && horz_offset < h_total) |=> (h_q == $past(horz_offset)))
    else $error("horizontal offset not applied at reference frame start");
  a_fine_free: assert property (@(posedge clock) disable iff (srst)
    !locked_mode |=> (fine_phase_q == '0))
    else $error("fine phase offset applied without reference lock");
  a_vblank_lines: assert property (@(posedge clock) disable iff (srst)
    (v_q < vb_last) |=> (out_blank_q && out_data_q == gco_pkg::BLACK_LEVEL))
    else $error("line inside vertical blanking was not blanked");
  a_wide_625: assert property (@(posedge clock) disable iff (srst)
    (std625_q && vblank_wide && v_q == (gco_pkg::VB_WIDE_625 - 10'h001)) |=> out_blank_q)
    else $error("wide 625 blanking ended early");
  a_mute_black: assert property (@(posedge clock) disable iff (srst)
    (mute_q == gco_pkg::GCO_MUTE_NOISE && noisy && pat_q == gco_pkg::GCO_PAT_OFF)
      |=> (out_data_q == gco_pkg::BLACK_LEVEL))
    else $error("noisy input not muted");
  a_freeze_flag: assert property (@(posedge clock) disable iff (srst)
    (mute_q == gco_pkg::GCO_FREEZE_NOISE && !in_ok) |=> freeze_q)
    else $error("freeze not requested on lost input lock");
  a_pattern_frame: assert property (@(posedge clock) disable iff (srst)
    (!frame_end) |=> $stable(pat_q) && $stable(mute_q))
    else $error("pattern or mute changed inside a frame");
  a_std_frame: assert property (@(posedge clock) disable iff (srst)
    (!frame_end) |=> $stable(std625_q))
    else $error("line standard changed inside a frame");
  a_sch_range: assert property (@(posedge clock) disable iff (srst)
    ##1 ({1'b0, sch_phase_q} < gco_pkg::DEG_FULL))
    else $error("subcarrier phase out of range");
  a_follow_input: assert property (@(posedge clock) disable iff (srst)
    (!genlock_en && in_edge) |=> (h_q == '0 && v_q == '0))
    else $error("output did not follow input frame start");
endmodule : gco_ctrl
`default_nettype wire

// [pkg/gco_pkg.sv]
// Shared constants and types for the genlocked composite output controller
package gco_pkg;
  localparam int unsigned CNT_W          = 10;
  localparam int unsigned PIX_W          = 10;
  localparam int unsigned FINE_W         = 4;
  localparam int unsigned DEG_W          = 9;
  localparam int unsigned FIFO_DEPTH     = 8;
  // Clocks per line and lines per frame for each standard, and the shared active picture start clock
  localparam logic [9:0]  H_TOTAL_525    = 10'h35a;  // 858
  localparam logic [9:0]  H_TOTAL_625    = 10'h360;  // 864
  localparam logic [9:0]  H_ACTIVE_START = 10'h08a;  // 138
  localparam logic [9:0]  V_TOTAL_525    = 10'h20d;  // 525
  localparam logic [9:0]  V_TOTAL_625    = 10'h271;  // 625
  // Last blanked line, counting lines from 1
  localparam logic [9:0]  VB_NARROW_525  = 10'h009;
  localparam logic [9:0]  VB_NARROW_625  = 10'h006;
  localparam logic [9:0]  VB_WIDE_525    = 10'h014;
  localparam logic [9:0]  VB_WIDE_625    = 10'h016;
  // Sample levels
  localparam logic [9:0]  BLACK_LEVEL    = 10'h040;
  localparam logic [9:0]  SETUP_OFFSET   = 10'h01e;
  localparam logic [9:0]  PIX_MAX        = 10'h3ac;
  localparam int unsigned BAR_SHIFT      = 7;
  localparam logic [9:0]  DEG_FULL       = 10'h168;  // 360 degrees

  typedef enum logic [1:0] {GCO_MUTE_NONE, GCO_MUTE_NOISE, GCO_FREEZE_NOISE} gco_mute_e;
  typedef enum logic [1:0] {GCO_PAT_OFF, GCO_PAT_BLACK, GCO_PAT_BARS} gco_pat_e;

  // Luma of the eight colour bars, white to black
  function automatic logic [9:0] bar_level(input logic [2:0] idx);
    case (idx)
      3'h0:    bar_level = 10'h3ac;
      3'h1:    bar_level = 10'h36a;
      3'h2:    bar_level = 10'h2f0;
      3'h3:    bar_level = 10'h2ae;
      3'h4:    bar_level = 10'h1f0;
      3'h5:    bar_level = 10'h1ae;
      3'h6:    bar_level = 10'h134;
      default: bar_level = 10'h040;
    endcase
  endfunction : bar_level
endpackage : gco_pkg

// [verilog/gco_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module gco_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             s_valid,
  input  wire logic [WIDTH-1:0] s_data,
  output logic                  s_ready_q,
  output logic                  m_valid,
  output logic [WIDTH-1:0]      m_data,
  input  wire logic             m_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // Ready is registered so the source sees a clean level
  always_comb begin
    push    = s_valid && s_ready_q;
    pop     = m_valid && m_ready;
    m_valid = (cnt_q != '0);
    m_data  = mem_q[rd_q];
    wr_d    = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d    = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      s_ready_q <= 1'b0;
    end else begin
      wr_q      <= wr_d;
      rd_q      <= rd_d;
      cnt_q     <= cnt_d;
      s_ready_q <= (cnt_d < (AW+1)'(DEPTH));
    end
    if (push) begin
      mem_q[wr_q] <= s_data;
    end
  end
endmodule : gco_fifo
`default_nettype wire

// [tb/gco_ref_model.sv]
// Behavioural house reference feeding the genlock inputs
`timescale 1ns/1ps
`default_nettype none
module gco_ref_model (
  input  wire logic       clock,
  input  wire logic       present,
  input  wire logic       fire,
  input  wire logic [8:0] phase,
  output logic            ref_present,
  output logic            ref_vsync,
  output logic [8:0]      ref_sch_phase
);
  logic [2:0] width_q = 3'h0;
  // Frame pulse held four clocks so the synchroniser sees a clean edge
  always @(posedge clock) begin
    width_q <= fire ? 3'h4 : ((width_q != 3'h0) ? width_q - 3'h1 : 3'h0);
  end
  // An absent reference shows no pulse and a scrambled phase, not the last one
  assign ref_vsync     = present && (width_q != 3'h0);
  assign ref_present   = present;
  assign ref_sch_phase = present ? phase : ~phase;
endmodule : gco_ref_model
`default_nettype wire

// [tb/genlocked_composite_output_ctrl_tb_top.sv]
// Self-checking bench for the composite output controller
`timescale 1ns/1ps
`default_nettype none
module genlocked_composite_output_ctrl_tb_top;
  logic       clock = 1'b0, srst = 1'b1, genlock_en = 1'b0, vblank_wide = 1'b0, setup_en = 1'b0;
  logic       in_locked = 1'b1, in_frame_start = 1'b0, in_line_625 = 1'b0, in_valid = 1'b0;
  logic       ref_on = 1'b0, ref_fire = 1'b0, std625 = 1'b0;
  logic [9:0] vert_offset = 10'h000, horz_offset = 10'h000, in_data = 10'h000, dword = 10'h000, dh;
  logic [3:0] fine_offset = 4'h0;
  logic [8:0] sch_adjust = 9'h000, ref_phase = 9'h000, ref_sch_phase;
  logic [1:0] mute_mode = 2'h0, pattern_sel = 2'h0;
  logic       ref_present, ref_vsync, in_ready_q, out_blank_q, out_hsync_q, out_vsync_q;
  logic       out_std625_q, out_genlocked_q, freeze_q;
  logic [9:0] out_data_q;
  logic [3:0] fine_phase_q;
  logic [8:0] sch_phase_q;
  int         num_errors = 0, total_checks = 0, n1, n2;

  gco_ref_model i_ref (.clock(clock), .present(ref_on), .fire(ref_fire), .phase(ref_phase),
    .ref_present(ref_present), .ref_vsync(ref_vsync), .ref_sch_phase(ref_sch_phase));
  gco_ctrl #(.DEPTH(gco_pkg::FIFO_DEPTH)) i_dut (.clock(clock), .srst(srst), .genlock_en(genlock_en),
    .vert_offset(vert_offset), .horz_offset(horz_offset), .fine_offset(fine_offset), .sch_adjust(sch_adjust),
    .ref_sch_phase(ref_sch_phase), .vblank_wide(vblank_wide), .mute_mode(mute_mode), .pattern_sel(pattern_sel),
    .setup_en(setup_en), .ref_present(ref_present), .ref_vsync(ref_vsync), .in_locked(in_locked),
    .in_frame_start(in_frame_start), .in_line_625(in_line_625), .in_valid(in_valid), .in_data(in_data),
    .in_ready_q(in_ready_q), .out_data_q(out_data_q), .out_blank_q(out_blank_q), .out_hsync_q(out_hsync_q),
    .out_vsync_q(out_vsync_q), .out_std625_q(out_std625_q), .out_genlocked_q(out_genlocked_q),
    .fine_phase_q(fine_phase_q), .sch_phase_q(sch_phase_q), .freeze_q(freeze_q));

  always #10 clock = ~clock;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : check

  // Flags are read 1 ns after an edge so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Fire reference or input frame start, count clocks to the chosen sync pulse
  task automatic fire_meas(input logic [9:0] v, input logic [9:0] h, input logic vs, input logic fs, output int n);
    @(posedge clock);
    vert_offset <= v;
    horz_offset <= h;
    ref_fire <= !fs;
    in_frame_start <= fs;
    @(posedge clock);
    ref_fire <= 1'b0;
    // Skipping the synchroniser delay hides pulses of the old timing
    n = fs ? 0 : 6;
    if (!fs) tick(6);
    do begin
      tick(1);
      n++;
    end while (((vs ? out_vsync_q : out_hsync_q) !== 1'b1) && n < 2000);
    in_frame_start <= 1'b0;
  endtask : fire_meas

  // Jump to line ln and settle at about clock 150 of it
  task automatic line_at(input logic [9:0] ln);
    int n;
    fire_meas(ln - 10'h001, 10'h352, 1'b0, 1'b0, n);
    tick(150);
  endtask : line_at

  task automatic frame_end;
    int n;
    fire_meas(std625 ? 10'h270 : 10'h20c, 10'h352, 1'b1, 1'b0, n);
    std625 = in_line_625;
  endtask : frame_end

  function automatic logic [9:0] pic(input logic [9:0] d);
    logic [10:0] s;
    s = {1'b0, d} + {1'b0, gco_pkg::SETUP_OFFSET};
    if (!setup_en || std625) pic = d;
    else pic = (s > {1'b0, gco_pkg::PIX_MAX}) ? gco_pkg::PIX_MAX : s[9:0];
  endfunction : pic

  function automatic logic [8:0] sch_sum(input logic [8:0] a, input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    sch_sum = (s >= gco_pkg::DEG_FULL) ? 9'(s - gco_pkg::DEG_FULL) : s[8:0];
  endfunction : sch_sum

  // Last blanked line must blank, the next one must carry picture
  task automatic blank_pair(input logic wide, input logic [9:0] last);
    vblank_wide <= wide;
    line_at(last - 10'h001);
    check(out_blank_q === 1'b1, "last blank line shows picture");
    line_at(last);
    check(out_blank_q === 1'b0 && out_data_q === pic(dword), "first picture line wrong");
  endtask : blank_pair

  task automatic frame_look(input logic [1:0] pat, input logic [1:0] mute, input logic lock);
    pattern_sel <= pat;
    mute_mode <= mute;
    in_locked <= lock;
    frame_end;
    line_at(10'h01e);
  endtask : frame_look

  initial begin
    void'($urandom(32'h4c25));
    tick(10);
    check(out_blank_q === 1'b1 && out_data_q === gco_pkg::BLACK_LEVEL, "reset level");
    check(out_std625_q === 1'b0 && freeze_q === 1'b0, "reset modes");
    @(posedge clock);
    srst <= 1'b0;
    tick(2);
    // Fill the buffer during blanking until it refuses
    in_valid <= 1'b1;
    n1 = 0;
    repeat (20) begin
      #2;
      n2 = int'(in_ready_q === 1'b1);
      @(posedge clock);
      n1 += n2;
      in_data <= 10'($urandom_range(64, 900));
    end
    tick(1);
    check(n1 == 8 && in_ready_q === 1'b0, "buffer depth");
    dword = 10'($urandom_range(64, 800));
    in_data <= dword;
    $display("test fifo done");
    ref_on <= 1'b1;
    fire_meas(10'h005, 10'h005, 1'b1, 1'b0, n1);
    check(n1 == 2000 && out_genlocked_q === 1'b0, "reference not ignored");
    fire_meas(10'h000, 10'h000, 1'b1, 1'b1, n1);
    check(n1 < 50, "input frame start ignored");
    $display("test genlock off done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      genlock_en <= 1'b1;
      ref_on <= 1'b0;
      fine_offset <= 4'($urandom);
      sch_adjust <= (k == 0) ? 9'h167 : 9'($urandom_range(0, 359));
      ref_phase <= (k == 0) ? 9'h167 : 9'($urandom_range(0, 359));
      tick(6);
      check(out_genlocked_q === 1'b0 && sch_phase_q === sch_adjust, "free run");
      ref_on <= 1'b1;
      tick(6);
      check(out_genlocked_q === 1'b1 && fine_phase_q === fine_offset, "lock or fine");
      check(sch_phase_q === sch_sum(sch_adjust, ref_phase), "sch phase");
    end
    $display("test lock done");
    dh = 10'($urandom_range(1, 400));
    fire_meas(10'h00a, 10'h064, 1'b0, 1'b0, n1);
    fire_meas(10'h00a, 10'h064 + dh, 1'b0, 1'b0, n2);
    check(n1 - n2 == int'(dh), "horizontal offset");
    fire_meas(10'h20c, 10'h320, 1'b1, 1'b0, n1);
    fire_meas(10'h20b, 10'h320, 1'b1, 1'b0, n2);
    check(n2 - n1 == int'(gco_pkg::H_TOTAL_525), "vertical offset");
    $display("test offsets done");
    blank_pair(1'b0, gco_pkg::VB_NARROW_525);
    blank_pair(1'b1, gco_pkg::VB_WIDE_525);
    setup_en <= 1'b1;
    pattern_sel <= 2'h1;
    line_at(10'h01e);
    check(out_data_q === pic(dword), "setup or early pattern");
    frame_look(2'h1, 2'h0, 1'b1);
    check(out_data_q === gco_pkg::BLACK_LEVEL, "black pattern");
    frame_look(2'h2, 2'h0, 1'b1);
    check(out_data_q === 10'h36a, "bar pattern");
    frame_look(2'h0, 2'h1, 1'b0);
    check(out_data_q === gco_pkg::BLACK_LEVEL && freeze_q === 1'b0, "mute on noise");
    frame_look(2'h0, 2'h2, 1'b0);
    check(freeze_q === 1'b1, "freeze on noise");
    in_locked <= 1'b1;
    tick(8);
    check(freeze_q === 1'b0, "freeze held after lock");
    frame_look(2'h0, 2'h0, 1'b0);
    check(out_data_q === pic(dword) && freeze_q === 1'b0, "no muting");
    $display("test conditioning done");
    in_line_625 <= 1'b1;
    in_locked <= 1'b1;
    frame_end;
    check(out_std625_q === 1'b1, "line standard");
    blank_pair(1'b0, gco_pkg::VB_NARROW_625);
    blank_pair(1'b1, gco_pkg::VB_WIDE_625);
    $display("test 625 done");
    report_and_stop();
  end

  // Run is near 7k clocks; the limit leaves ample slack
  initial begin
    repeat (80000) @(posedge clock);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : genlocked_composite_output_ctrl_tb_top
`default_nettype wire
